/* design/sbl_loader.sv */
// Serial bootstrap loader top: strap capture, autobaud, download to RAM,
// timeout, jump, echo transmitter and software register port.
// Assumes synchronous inputs, a single-cycle RAM write port outside.
//
// Function
// R1: Boot strap selects reset vector from the internal boot ROM.
// R2: Serial port starts fast, switches to slow rate on matching first character.
// R3: Rate chosen from first character only, kept for the whole download.
// R4: Received program bytes are written to RAM in arrival order.
// R5: After the download a jump hands control to the loaded program.
// R6: Receiver finds start edge, checks start low, samples data mid-bit.
// R7: Fast-rate decode of slow sync as C0 or E0 selects slow rate.
// R8: Host sends all-ones first; other first characters may raise errors.
// R9: Init sets the stack pointer and index base to register block.
// R10: Wired-OR select bit set at init; transmit pin then only pulls low.
// R11: Receiver and transmitter both enabled; transmitter echoes bytes to host.
// R12: Download ends when no character arrives within the compare-register delay.
// R13: Boot mode is privileged, allowing configuration register programming.
// R14: Expansion bus stays available to be enabled after boot reset.
// R15: Jump target is the first RAM address written.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module sbl_loader
    import sbl_pkg::*;
#(
    parameter logic [15:0] FAST_BIT_CYCLES = 16'(FAST_BIT_CYC),
    parameter logic [15:0] SLOW_BIT_CYCLES = 16'(SLOW_BIT_CYC)
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic boot_mode_in,
    input wire logic rxd_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic irq_out,
    output logic txd_out,
    output logic txd_oe_out,
    output logic ram_we_out,
    output logic [15:0] ram_addr_out,
    output logic [7:0] ram_wdata_out,
    output logic jump_out,
    output logic [15:0] jump_addr_out,
    output logic boot_vector_sel_out,
    output logic privileged_out,
    output logic expansion_allow_out,
    output logic [15:0] sp_init_out,
    output logic [15:0] index_base_out
);

    sbl_top_s s_reg;
    sbl_top_s s_next;
    sbl_rxbyte_s rxb;
    logic rx_en;
    logic [15:0] bit_cyc;
    logic tout_hit;
    logic [3:0] ev;
    logic echo_go;

    // ****************************************
    // Receiver
    // ****************************************
    assign rx_en = s_reg.ctrl[CTRL_RX_EN] && (s_reg.state == ST_SYNC || s_reg.state == ST_LOAD);
    assign bit_cyc = s_reg.slow ? SLOW_BIT_CYCLES : FAST_BIT_CYCLES; // R2
    assign tout_hit = (s_reg.tout >= s_reg.cmp_delay);
    assign echo_go = s_reg.state == ST_LOAD && rxb.valid && s_reg.ctrl[CTRL_TX_EN] && !s_reg.tx_busy;

    sbl_rx u_rx (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .rx_in(rxd_in),
        .enable_in(rx_en),
        .bit_cycles_in(bit_cyc),
        .byte_out(rxb)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        ev = 4'h0;
        s_next.ram_we = 1'b0;
        s_next.jump = 1'b0;
        s_next.rdata = 32'h0000_0000;

        // Strap caught one edge after release, never in the reset branch
        if (!s_reg.strap_done) begin
            s_next.strap_done = 1'b1;
            s_next.boot = boot_mode_in; // R1 R13
            s_next.sp = STACK_INIT; // R9
            s_next.ix = REG_BLOCK_BASE; // R9
            s_next.state = boot_mode_in ? ST_SYNC : ST_IDLE;
        end

        case (s_reg.state)
            ST_IDLE: begin
                s_next.state = s_next.state;
            end
            ST_SYNC: begin
                if (rxb.valid) begin
                    // Only the first character can change the rate
                    if (rxb.data == SLOW_PAT_A || rxb.data == SLOW_PAT_B) begin // R7 R3
                        s_next.slow = 1'b1;
                        ev[EV_SLOW] = 1'b1;
                    end else if (rxb.data != SYNC_CHAR) begin // R8
                        ev[EV_ERR] = 1'b1;
                    end
                    s_next.state = ST_LOAD;
                    s_next.tout = 16'h0000;
                    s_next.pre = 8'h00;
                end else if (rxb.ferr) begin
                    ev[EV_ERR] = 1'b1;
                end
            end
            ST_LOAD: begin
                if (rxb.valid) begin
                    s_next.ram_we = 1'b1; // R4
                    s_next.ram_addr = RAM_BASE + s_reg.count; // R4
                    s_next.ram_data = rxb.data;
                    s_next.count = s_reg.count + 16'h0001;
                    s_next.tout = 16'h0000; // R12
                    s_next.pre = 8'h00;
                    ev[EV_RX] = 1'b1;
                end else if (tout_hit) begin
                    s_next.state = ST_JUMP; // R12
                end else begin
                    s_next.pre = s_reg.pre + 8'h01;
                    if (s_reg.pre == 8'hFF) begin
                        s_next.tout = s_reg.tout + 16'h0001;
                    end
                end
                if (rxb.ferr) begin
                    ev[EV_ERR] = 1'b1;
                end
            end
            ST_JUMP: begin
                s_next.jump = 1'b1; // R5
                s_next.jaddr = RAM_BASE; // R15
                s_next.state = ST_DONE;
                ev[EV_DONE] = 1'b1;
            end
            ST_DONE: begin
                s_next.state = ST_DONE;
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase

        // ****************************************
        // Echo transmitter
        // ****************************************
        // A byte arriving while the echo is still busy is not echoed
        if (echo_go) begin
            s_next.tx_busy = 1'b1; // R11
            s_next.tx_shift = {1'b1, rxb.data, 1'b0};
            s_next.tx_cnt = bit_cyc - 16'h0001;
            s_next.tx_bitn = 4'h0;
            s_next.txd = 1'b0;
        end else if (s_reg.tx_busy) begin
            if (s_reg.tx_cnt == 16'h0000) begin
                s_next.tx_cnt = bit_cyc - 16'h0001;
                if (s_reg.tx_bitn == TX_LAST_BIT) begin
                    s_next.tx_busy = 1'b0;
                    s_next.txd = 1'b1;
                end else begin
                    s_next.tx_shift = {1'b1, s_reg.tx_shift[9:1]};
                    s_next.txd = s_reg.tx_shift[1];
                    s_next.tx_bitn = s_reg.tx_bitn + 4'h1;
                end
            end else begin
                s_next.tx_cnt = s_reg.tx_cnt - 16'h0001;
            end
        end
        // Wired-OR keeps the pin off while idle, so a listener is never fought
        s_next.txd_oe = s_next.periph_ctrl[WIRED_OR_BIT] ? !s_next.txd : 1'b1; // R10

        // ****************************************
        // Register port
        // ****************************************
        if (reg_wr_in) begin
            case (reg_addr_in)
                OFS_CTRL: s_next.ctrl = reg_wdata_in[1:0];
                OFS_PERIPH_CTRL: s_next.periph_ctrl = reg_wdata_in[7:0];
                OFS_CMP_DELAY: s_next.cmp_delay = reg_wdata_in[15:0];
                OFS_STAT: s_next.status = s_reg.status & ~reg_wdata_in[3:0];
                OFS_MASK: s_next.mask = reg_wdata_in[3:0];
                default: s_next.ctrl = s_next.ctrl;
            endcase
        end
        // Set wins over a clear in the same cycle
        s_next.status = s_next.status | ev;
        if (s_next.periph_ctrl[WIRED_OR_BIT] != s_reg.periph_ctrl[WIRED_OR_BIT]) begin
            s_next.txd_oe = s_next.periph_ctrl[WIRED_OR_BIT] ? !s_next.txd : 1'b1; // R10
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                OFS_CTRL: s_next.rdata = {30'h0000_0000, s_reg.ctrl};
                OFS_PERIPH_CTRL: s_next.rdata = {24'h00_0000, s_reg.periph_ctrl};
                OFS_CMP_DELAY: s_next.rdata = {16'h0000, s_reg.cmp_delay};
                OFS_STAT: s_next.rdata = {28'h000_0000, s_reg.status};
                OFS_MASK: s_next.rdata = {28'h000_0000, s_reg.mask};
                OFS_INFO: s_next.rdata = {12'h000, s_reg.state, s_reg.slow, s_reg.count};
                default: s_next.rdata = 32'h0000_0000;
            endcase
        end
        s_next.irq = |(s_next.status & s_next.mask);
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_reg <= '0;
            s_reg.ctrl <= CTRL_RESET; // R11
            s_reg.periph_ctrl <= PERIPH_CTRL_RESET; // R10
            s_reg.cmp_delay <= CMP_DELAY_RESET; // R12
            s_reg.txd <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata_out = s_reg.rdata;
    assign irq_out = s_reg.irq;
    assign txd_out = s_reg.txd;
    assign txd_oe_out = s_reg.txd_oe;
    assign ram_we_out = s_reg.ram_we;
    assign ram_addr_out = s_reg.ram_addr;
    assign ram_wdata_out = s_reg.ram_data;
    assign jump_out = s_reg.jump;
    assign jump_addr_out = s_reg.jaddr;
    assign boot_vector_sel_out = s_reg.boot; // R1
    assign privileged_out = s_reg.boot; // R13
    assign expansion_allow_out = s_reg.strap_done; // R14
    assign sp_init_out = s_reg.sp;
    assign index_base_out = s_reg.ix;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    sequence timeout_seen;
        s_reg.state == ST_LOAD && !rxb.valid && tout_hit;
    endsequence

    sequence jump_seen;
        s_reg.state == ST_JUMP ##1 (jump_out && jump_addr_out == RAM_BASE) ##1 !jump_out;
    endsequence

    boot_vector_a: assert property ( // R1
        !s_reg.strap_done |=> (boot_vector_sel_out == $past(boot_mode_in))
    ) else $error("boot vector select not taken from strap");

    fast_start_a: assert property ( // R2
        s_reg.state == ST_SYNC |-> (!s_reg.slow && bit_cyc == FAST_BIT_CYCLES)
    ) else $error("sync not at fast rate");

    rate_hold_a: assert property ( // R3
        (s_reg.state != ST_SYNC && $past(s_reg.state) != ST_SYNC) |-> $stable(s_reg.slow)
    ) else $error("rate changed after first character");

    slow_pick_a: assert property ( // R7
        (s_reg.state == ST_SYNC && rxb.valid && (rxb.data == SLOW_PAT_A || rxb.data == SLOW_PAT_B))
        |=> (s_reg.slow && s_reg.state == ST_LOAD)
    ) else $error("slow pattern did not select slow rate");

    ram_write_a: assert property ( // R4
        (s_reg.state == ST_LOAD && rxb.valid)
        |=> (ram_we_out && ram_wdata_out == $past(rxb.data)
             && ram_addr_out == RAM_BASE + $past(s_reg.count))
    ) else $error("received byte not written to RAM");

    jump_after_a: assert property ( // R5 R12 R15
        timeout_seen |=> jump_seen
    ) else $error("timeout did not jump to first RAM address");

    init_regs_a: assert property ( // R9
        s_reg.strap_done |-> (index_base_out == REG_BLOCK_BASE && sp_init_out == STACK_INIT)
    ) else $error("stack or index base not initialised");

    wired_or_a: assert property ( // R10
        (s_reg.periph_ctrl[WIRED_OR_BIT] && txd_oe_out) |-> !txd_out
    ) else $error("transmit pin driven high in wired-OR mode");

    echo_start_a: assert property ( // R11
        echo_go |=> (!txd_out && s_reg.tx_busy) ##1 !txd_out
    ) else $error("received byte not echoed");

    privileged_a: assert property ( // R13 R14
        s_reg.boot |-> (privileged_out && expansion_allow_out)
    ) else $error("boot mode not privileged or expansion blocked");

endmodule

/* design/sbl_pkg.sv */
// Constants, types and state carriers for the serial bootstrap loader.
// Assumes a single 50 MHz clock and a synchronous serial receive input.
package sbl_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 50_000_000;
    localparam int BAUD_FAST_HZ = 7812;
    localparam int BAUD_SLOW_HZ = 1200;
    localparam int FAST_BIT_CYC = CLK_HZ / BAUD_FAST_HZ;
    localparam int SLOW_BIT_CYC = CLK_HZ / BAUD_SLOW_HZ;
    localparam logic [15:0] CMP_DELAY_RESET = 16'h1000;

    // ****************************************
    // Characters and addresses
    // ****************************************
    localparam logic [7:0] SYNC_CHAR = 8'hFF;
    localparam logic [7:0] SLOW_PAT_A = 8'hC0;
    localparam logic [7:0] SLOW_PAT_B = 8'hE0;
    localparam logic [15:0] REG_BLOCK_BASE = 16'h1000;
    localparam logic [15:0] STACK_INIT = 16'h00FF;
    localparam logic [15:0] RAM_BASE = 16'h0000;

    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PERIPH_CTRL = 8'h04;
    localparam logic [7:0] OFS_CMP_DELAY = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_INFO = 8'h14;
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_TX_EN = 1;
    localparam int WIRED_OR_BIT = 5;
    localparam int EV_RX = 0;
    localparam int EV_SLOW = 1;
    localparam int EV_DONE = 2;
    localparam int EV_ERR = 3;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [7:0] PERIPH_CTRL_RESET = 8'h20;
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    localparam logic [3:0] RX_LAST_BIT = 4'h7;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_SYNC = 3'h1, ST_LOAD = 3'h3, ST_JUMP = 3'h2, ST_DONE = 3'h6
    } sbl_state_e;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h0, RX_START = 2'h1, RX_DATA = 2'h3, RX_STOP = 2'h2
    } sbl_rxph_e;

    typedef struct packed {
        logic valid;
        logic ferr;
        logic [7:0] data;
    } sbl_rxbyte_s;

    typedef struct packed {
        sbl_rxph_e phase;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic rx_prev;
        sbl_rxbyte_s out;
    } sbl_rx_s;

    typedef struct packed {
        sbl_state_e state;
        logic strap_done;
        logic boot;
        logic [15:0] sp;
        logic [15:0] ix;
        logic [1:0] ctrl;
        logic [7:0] periph_ctrl;
        logic [15:0] cmp_delay;
        logic [3:0] status;
        logic [3:0] mask;
        logic [31:0] rdata;
        logic irq;
        logic slow;
        logic [15:0] count;
        logic ram_we;
        logic [15:0] ram_addr;
        logic [7:0] ram_data;
        logic [7:0] pre;
        logic [15:0] tout;
        logic jump;
        logic [15:0] jaddr;
        logic tx_busy;
        logic [9:0] tx_shift;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bitn;
        logic txd;
        logic txd_oe;
    } sbl_top_s;

endpackage

/* design/sbl_rx.sv */
// Serial receiver: start edge, start check, mid-bit sampling, stop check.
// Assumes rx_in is synchronous and bit_cycles_in only changes while idle.
`timescale 1ns/1ps
module sbl_rx
    import sbl_pkg::*;
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic rx_in,
    input wire logic enable_in,
    input wire logic [15:0] bit_cycles_in,
    output sbl_rxbyte_s byte_out
);

    sbl_rx_s s_reg;
    sbl_rx_s s_next;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.out.valid = 1'b0;
        s_next.out.ferr = 1'b0;
        s_next.rx_prev = rx_in;
        case (s_reg.phase)
            RX_IDLE: begin
                if (enable_in && s_reg.rx_prev && !rx_in) begin // R6
                    s_next.phase = RX_START;
                    s_next.cnt = {1'b0, bit_cycles_in[15:1]};
                end
            end
            RX_START: begin
                if (s_reg.cnt == 16'h0000) begin
                    // Glitch on the line is dropped, not framed
                    s_next.phase = rx_in ? RX_IDLE : RX_DATA; // R6
                    s_next.cnt = bit_cycles_in - 16'h0001;
                    s_next.bitn = 4'h0;
                end else begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end
            end
            RX_DATA: begin
                if (s_reg.cnt == 16'h0000) begin
                    s_next.shift = {rx_in, s_reg.shift[7:1]};
                    s_next.cnt = bit_cycles_in - 16'h0001;
                    s_next.bitn = s_reg.bitn + 4'h1;
                    if (s_reg.bitn == RX_LAST_BIT) begin
                        s_next.phase = RX_STOP;
                    end
                end else begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end
            end
            RX_STOP: begin
                if (s_reg.cnt == 16'h0000) begin
                    s_next.phase = RX_IDLE;
                    s_next.out.data = s_reg.shift;
                    s_next.out.valid = rx_in;
                    s_next.out.ferr = !rx_in;
                end else begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end
            end
            default: begin
                s_next.phase = RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_reg <= '0;
            s_reg.rx_prev <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign byte_out = s_reg.out;

    // ****************************************
    // Checks
    // ****************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    start_check_a: assert property ( // R6
        (s_reg.phase == RX_START && s_reg.cnt == 16'h0000 && rx_in) |=> s_reg.phase == RX_IDLE
    ) else $error("false start bit accepted");

    edge_detect_a: assert property ( // R6
        (s_reg.phase == RX_IDLE && enable_in && s_reg.rx_prev && !rx_in)
        |=> (s_reg.phase == RX_START && s_reg.cnt == {1'b0, $past(bit_cycles_in[15:1])})
    ) else $error("start edge not taken at half bit");

endmodule

/* verification/sbl_host.sv */
// Host model for the loader's serial link: 8N1 frames, LSB first, echo decode.
// Assumes the transmit wire has a pull-up, so a released pin reads high.
`timescale 1ns/1ps
module sbl_host (
    input wire logic clk_in,
    input wire logic txd_in,
    input wire logic txd_oe_in,
    output logic rxd_out
);
    // ****************************************
    // Link drive and echo decode
    // ****************************************
    logic line;
    logic [7:0] echo_byte = 8'h00;
    int bitc = 16;

    // Wired-OR transmit pin: pulled high whenever it is released
    assign line = txd_oe_in ? txd_in : 1'b1;
    initial rxd_out = 1'b1;

    // Stop level is an argument so that framing faults can be sent on purpose
    task automatic send_frame(input logic [7:0] d, input int bc, input logic stop);
        bitc = bc;
        @(posedge clk_in);
        rxd_out <= 1'b0;
        repeat (bc) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            rxd_out <= d[i];
            repeat (bc) @(posedge clk_in);
        end
        rxd_out <= stop;
        repeat (bc) @(posedge clk_in);
        rxd_out <= 1'b1;
    endtask

    task automatic glitch(input int n);
        @(posedge clk_in);
        rxd_out <= 1'b0;
        repeat (n) @(posedge clk_in);
        rxd_out <= 1'b1;
    endtask

    // Echo comes back at the rate of the last frame sent
    always begin
        @(negedge line);
        repeat (bitc / 2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
            repeat (bitc) @(posedge clk_in);
            echo_byte[i] = line;
        end
        repeat (bitc) @(posedge clk_in);
    end
endmodule

/* verification/tb_top.sv */
// Testbench for the serial bootstrap loader: registers, autobaud, RAM, jump.
// Assumes sbl_host drives the receive line and decodes the echoed bytes.
`timescale 1ns/1ps
module tb_top
    import sbl_pkg::*;
;
    // ****************************************
    // Signals, monitor and tasks
    // ****************************************
    localparam int FB = 16;
    localparam int SB = 100;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic boot_mode_in = 1'b1;
    logic rxd_in;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0000_0000;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic irq_out, txd_out, txd_oe_out, ram_we_out, jump_out, jumped;
    logic boot_vector_sel_out, privileged_out, expansion_allow_out;
    logic [15:0] ram_addr_out, jump_addr_out, sp_init_out, index_base_out;
    logic [7:0] ram_wdata_out;
    logic [31:0] exp_data [4];
    int err_count = 0, comparisons = 0, n_we = 0, cyc = 0, last_we = 0, jump_gap = 0;

    always #10 clk_in = ~clk_in;

    // Short bit times keep the run brief; the 6.25 ratio still gives C0/E0
    sbl_loader #(.FAST_BIT_CYCLES(16'h0010), .SLOW_BIT_CYCLES(16'h0064)) sbl_loader_i (
        .clk_in, .rstn_in, .boot_mode_in, .rxd_in, .reg_addr_in, .reg_wdata_in,
        .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out, .txd_out, .txd_oe_out,
        .ram_we_out, .ram_addr_out, .ram_wdata_out, .jump_out, .jump_addr_out,
        .boot_vector_sel_out, .privileged_out, .expansion_allow_out, .sp_init_out,
        .index_base_out);

    sbl_host sbl_host_i (.clk_in(clk_in), .txd_in(txd_out), .txd_oe_in(txd_oe_out),
        .rxd_out(rxd_in));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            n_we = 0;
            jumped = 1'b0;
        end else begin
            cyc++;
            if (ram_we_out) begin
                check("ram_addr", 32'(ram_addr_out), 32'(n_we));
                check("ram_data", 32'(ram_wdata_out), exp_data[n_we]);
                n_we++;
                last_we = cyc;
            end
            if (jump_out) begin
                check("jump_addr", 32'(jump_addr_out), 32'h0000_0000);
                jumped = 1'b1;
                jump_gap = cyc - last_we;
            end
            check("txd_oe", 32'(txd_oe_out), 32'(!txd_out));
        end
    end

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 check($sformatf("reg_%h", a), reg_rdata_out, e);
    endtask

    task automatic do_reset(input logic boot);
        rstn_in <= 1'b0;
        boot_mode_in <= boot;
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask

    // Gap from last stored byte to jump must lie within 256 cycles of the compare value times 256
    task automatic wait_jump(input int toc);
        for (int i = 0; i < 4000 && !jumped; i++) @(posedge clk_in);
        if (!jumped) begin
            err_count++;
            report_and_stop();
        end else begin
            check("jump_gap", 32'(jump_gap >= (toc - 1) * 256 && jump_gap <= (toc + 1) * 256),
                32'h0000_0001);
        end
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        do_reset(1'b1);
        check("vector_sel", 32'(boot_vector_sel_out), 32'h0000_0001);
        check("privileged", 32'(privileged_out), 32'h0000_0001);
        check("expansion", 32'(expansion_allow_out), 32'h0000_0001);
        check("sp_init", 32'(sp_init_out), 32'h0000_00FF);
        check("index_base", 32'(index_base_out), 32'h0000_1000);
        reg_chk(OFS_CTRL, 32'h0000_0003);
        reg_chk(OFS_PERIPH_CTRL, 32'h0000_0020);
        reg_chk(OFS_CMP_DELAY, 32'h0000_1000);
        reg_chk(OFS_INFO, 32'h0002_0000);
        reg_wr(8'h18, 32'hFFFF_FFFF);
        reg_chk(8'h18, 32'h0000_0000);
        reg_wr(OFS_CMP_DELAY, 32'h0000_0008);
        reg_wr(OFS_MASK, 32'h0000_000F);
        sbl_host_i.send_frame(8'hFF, SB, 1'b1);
        reg_chk(OFS_INFO, 32'h0007_0000);
        reg_chk(OFS_STAT, 32'h0000_0002);
        check("irq_set", 32'(irq_out), 32'h0000_0001);
        reg_wr(OFS_STAT, 32'h0000_000F);
        repeat (2) @(posedge clk_in);
        #1 check("irq_clr", 32'(irq_out), 32'h0000_0000);
        exp_data = '{32'h0000_00A5, 32'h0000_003C, 32'h0000_0081, 32'h0000_0000};
        for (int i = 0; i < 3; i++) begin
            sbl_host_i.send_frame(exp_data[i][7:0], SB, 1'b1);
            repeat (10 * SB) @(posedge clk_in);
            check("echo", 32'(sbl_host_i.echo_byte), exp_data[i]);
        end
        wait_jump(8);
        check("ram_writes", 32'(n_we), 32'h0000_0003);
        reg_chk(OFS_STAT, 32'h0000_0005);
        reg_chk(OFS_INFO, 32'h000D_0003);
        // Fast host, with a glitch and a framing fault ahead of the byte
        do_reset(1'b1);
        reg_wr(OFS_CMP_DELAY, 32'h0000_0004);
        sbl_host_i.send_frame(8'hFF, FB, 1'b1);
        reg_chk(OFS_INFO, 32'h0006_0000);
        sbl_host_i.glitch(FB / 4);
        repeat (FB) @(posedge clk_in);
        sbl_host_i.send_frame(8'h33, FB, 1'b0);
        repeat (FB) @(posedge clk_in);
        reg_chk(OFS_STAT, 32'h0000_0008);
        exp_data[0] = 32'h0000_005A;
        sbl_host_i.send_frame(8'h5A, FB, 1'b1);
        repeat (10 * FB) @(posedge clk_in);
        check("echo", 32'(sbl_host_i.echo_byte), 32'h0000_005A);
        wait_jump(4);
        check("ram_writes", 32'(n_we), 32'h0000_0001);
        reg_chk(OFS_INFO, 32'h000C_0001);
        // Strap low: no boot ROM vector, no privilege
        do_reset(1'b0);
        check("vector_sel", 32'(boot_vector_sel_out), 32'h0000_0000);
        check("privileged", 32'(privileged_out), 32'h0000_0000);
        check("expansion", 32'(expansion_allow_out), 32'h0000_0001);
        reg_chk(OFS_INFO, 32'h0000_0000);
        report_and_stop();
    end
endmodule
